//--- hdl/cvpc_consts.svh
// offsets, field positions, reset values and fifo marks of the converter control block
`ifndef CVPC_CONSTS_SVH
`define CVPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register addresses on the peripheral bus
// ----------------------------------------------------------------------------
`define CVPC_CTRL_ADDR      24'hFF_FC30
`define CVPC_STAT_ADDR      24'hFF_FC32

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CVPC_CTRL_RESET     16'h0000
`define CVPC_STAT_RESET     16'h0000
`define CVPC_RDATA_RESET    16'h0000

// ----------------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------------
`define CVPC_S_IN_LOW       0
`define CVPC_S_OUT_HIGH     1
`define CVPC_S_PCM_SERVICE  2
`define CVPC_S_UNDERRUN     3
`define CVPC_S_OVERRUN      4
`define CVPC_S_IN_FREE_LO   5
`define CVPC_S_IN_FREE_HI   7
`define CVPC_S_OUT_FILL_LO  8
`define CVPC_S_OUT_FILL_HI  10

// ----------------------------------------------------------------------------
// fifo geometry and warning marks
// ----------------------------------------------------------------------------
`define CVPC_FIFO_DEPTH     8
`define CVPC_WARN_MARGIN    3
`define CVPC_COUNT_SAT      7

`endif

//--- hdl/cvpc_ctrl_status.sv
// control and status registers of the coded/linear audio converter
//
// Operation
// - 16-bit read/write control register; all implemented bits clear at reset.
// - module-on set opens access to other converter registers; clear disables module.
// - while module is disabled, the whole status register stays at reset value.
// - clock gate bit passes the 2 MHz codec clock when 1, blocks when 0.
// - pcm interrupt only raised while the pcm interrupt enable is 1.
// - level interrupt enable lets nearly-empty input or nearly-full output interrupt.
// - error interrupt enable lets output overrun or input underrun interrupt.
// - separate enables gate dma requests for coded output read and coded input write.
// - separate enables gate dma requests for linear output read and linear input write.
// - coded format: 00 mu-law, 01 a-law, 10 linear, 11 reserved.
// - companding bit: 0 linear to mu-law, 1 linear to a-law.
// - attenuation field arithmetic right-shifts conversion input by 0 to 3 bits.
// - log input expands to left-justified 13-bit a-law or 14-bit mu-law.
// - 16-bit read-only status, zero after reset and while module is off.
// - nearly-empty sets at three words left; irq, dma, clears on status read.
// - nearly-full sets at three free slots left; irq, dma, clears on read.
// - pcm service sets on unread output or empty input; read clears unless frozen.
// - underrun sets on read of empty input fifo; read clears unless frozen.
// - overrun sets on write of full output fifo; read clears unless frozen.
// - input free count: 111b when empty, 000b at seven or eight words.
// - output fill count: 000b when empty, 111b at seven or eight words.
// - both coded fifos are eight 16-bit words deep.
`include "cvpc_consts.svh"
`default_nettype none

module cvpc_ctrl_status #(
    parameter int FIFO_DEPTH  = `CVPC_FIFO_DEPTH,
    parameter int WARN_MARGIN = `CVPC_WARN_MARGIN,
    parameter int LEVEL_W     = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // peripheral bus
    input  wire logic [23:0]        bus_addr,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    input  wire logic [15:0]        bus_wdata,
    output logic [15:0]             bus_rdata,
    // emulator freeze pin
    input  wire logic               freeze_pin,
    // converter core
    input  wire logic [LEVEL_W-1:0] in_fifo_level,
    input  wire logic [LEVEL_W-1:0] out_fifo_level,
    input  wire logic               core_in_fifo_pop,
    input  wire logic               core_out_fifo_push,
    input  wire logic               linear_sample_out_full,
    input  wire logic               linear_sample_in_empty,
    input  wire logic [7:0]         log_sample,
    input  wire logic [15:0]        linear_sample_in,
    // outputs to core, dma controller and interrupt unit
    output logic                    converter_access_en,
    output logic                    codec_clk_en,
    output cvpc_pkg::cvpc_fmt_t     coded_format_sel,
    output logic                    companding_format_sel,
    output logic [15:0]             shaped_sample,
    output logic                    irq,
    output cvpc_pkg::cvpc_dma_t     dma_req
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    // the 3-bit count fields only describe an eight-word fifo
    if (FIFO_DEPTH != `CVPC_FIFO_DEPTH) begin : g_depth_bad
        $error("fifo depth must be eight words");
    end
    if (WARN_MARGIN < 1 || WARN_MARGIN >= FIFO_DEPTH) begin : g_margin_bad
        $error("warning margin must lie inside the fifo");
    end

    localparam int CTRL_W = $bits(cvpc_pkg::cvpc_ctrl_t);
    localparam logic [LEVEL_W-1:0] LOW_LEVEL  = LEVEL_W'(WARN_MARGIN);
    localparam logic [LEVEL_W-1:0] HIGH_LEVEL = LEVEL_W'(FIFO_DEPTH - WARN_MARGIN);
    localparam logic [LEVEL_W-1:0] FULL_LEVEL = LEVEL_W'(FIFO_DEPTH);
    localparam logic [LEVEL_W-1:0] SAT_LEVEL  = LEVEL_W'(`CVPC_COUNT_SAT);

    cvpc_pkg::cvpc_state_t st_q;
    cvpc_pkg::cvpc_state_t st_d;
    cvpc_pkg::cvpc_flags_t ev;
    cvpc_pkg::cvpc_flags_t clr;
    logic [15:0]           shaped_w;
    logic [15:0]           stat_word;
    logic [2:0]            in_free;
    logic [2:0]            out_fill;
    logic                  frozen;
    logic                  ctrl_hit;
    logic                  stat_hit;
    logic                  stat_read;
    logic                  in_low_now;
    logic                  out_high_now;
    logic                  pcm_need_now;

    // ------------------------------------------------------------------------
    // sample shaping for linear-to-coded conversion
    // ------------------------------------------------------------------------
    cvpc_shaper u_shaper (
        .log_sample       (log_sample),
        .linear_sample_in (linear_sample_in),
        .fmt              (st_q.ctrl.coded_format_sel),
        .atten            (st_q.ctrl.atten),
        .shaped           (shaped_w)
    );

    // ------------------------------------------------------------------------
    // fifo count fields
    // ------------------------------------------------------------------------
    always_comb begin
        // seven and eight words share a code; the field is only three bits
        if (in_fifo_level >= SAT_LEVEL) begin
            in_free = 3'h0;
        end else begin
            in_free = 3'(SAT_LEVEL - in_fifo_level);
        end
        if (out_fifo_level >= SAT_LEVEL) begin
            out_fill = 3'h7;
        end else begin
            out_fill = out_fifo_level[2:0];
        end
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.freeze_sync = {st_q.freeze_sync[0], freeze_pin};
        frozen = st_q.freeze_sync[1];
        ctrl_hit = (bus_addr == `CVPC_CTRL_ADDR);
        stat_hit = (bus_addr == `CVPC_STAT_ADDR);
        stat_read = bus_rd && stat_hit;

        if (bus_wr && ctrl_hit) begin
            st_d.ctrl = cvpc_pkg::cvpc_ctrl_t'(bus_wdata[CTRL_W-1:0]);
        end

        // level conditions become events on their rising edge only
        in_low_now = (in_fifo_level == LOW_LEVEL);
        out_high_now = (out_fifo_level >= HIGH_LEVEL);
        pcm_need_now = linear_sample_out_full || linear_sample_in_empty;
        st_d.seen.in_low_seen = in_low_now;
        st_d.seen.out_high_seen = out_high_now;
        st_d.seen.pcm_need_seen = pcm_need_now;

        ev.in_fifo_low = in_low_now && !st_q.seen.in_low_seen;
        ev.out_fifo_high = out_high_now && !st_q.seen.out_high_seen;
        ev.pcm_service = pcm_need_now && !st_q.seen.pcm_need_seen;
        ev.in_fifo_underrun = core_in_fifo_pop && (in_fifo_level == '0);
        ev.out_fifo_overrun = core_out_fifo_push && (out_fifo_level == FULL_LEVEL);

        // freeze keeps the error and service flags for the emulator to see
        clr.in_fifo_low = stat_read;
        clr.out_fifo_high = stat_read;
        clr.pcm_service = stat_read && !frozen;
        clr.in_fifo_underrun = stat_read && !frozen;
        clr.out_fifo_overrun = stat_read && !frozen;

        if (st_q.ctrl.module_on) begin
            st_d.flags = (st_q.flags & ~clr) | ev;
        end else begin
            st_d.flags = '0;
        end

        // read data reflects the flags held before this read
        stat_word = `CVPC_STAT_RESET;
        if (st_q.ctrl.module_on) begin
            stat_word[`CVPC_S_IN_LOW] = st_q.flags.in_fifo_low;
            stat_word[`CVPC_S_OUT_HIGH] = st_q.flags.out_fifo_high;
            stat_word[`CVPC_S_PCM_SERVICE] = st_q.flags.pcm_service;
            stat_word[`CVPC_S_UNDERRUN] = st_q.flags.in_fifo_underrun;
            stat_word[`CVPC_S_OVERRUN] = st_q.flags.out_fifo_overrun;
            stat_word[`CVPC_S_IN_FREE_HI:`CVPC_S_IN_FREE_LO] = in_free;
            stat_word[`CVPC_S_OUT_FILL_HI:`CVPC_S_OUT_FILL_LO] = out_fill;
        end
        if (bus_rd) begin
            if (ctrl_hit) begin
                st_d.rdata = {(16 - CTRL_W)'(0), st_q.ctrl};
            end else if (stat_hit) begin
                st_d.rdata = stat_word;
            end else begin
                st_d.rdata = `CVPC_RDATA_RESET;
            end
        end

        st_d.irq = st_d.ctrl.module_on && (
            (st_d.ctrl.pcm_irq_en && st_d.flags.pcm_service) ||
            (st_d.ctrl.fifo_level_irq_en &&
             (st_d.flags.in_fifo_low || st_d.flags.out_fifo_high)) ||
            (st_d.ctrl.fifo_error_irq_en &&
             (st_d.flags.in_fifo_underrun || st_d.flags.out_fifo_overrun)));

        st_d.dma_req.coded_in = st_d.ctrl.module_on && st_d.ctrl.coded_in_dma_en &&
                                st_d.flags.in_fifo_low;
        st_d.dma_req.coded_out = st_d.ctrl.module_on && st_d.ctrl.coded_out_dma_en &&
                                 st_d.flags.out_fifo_high;
        st_d.dma_req.linear_out = st_d.ctrl.module_on && st_d.ctrl.linear_out_dma_en &&
                                  linear_sample_out_full;
        st_d.dma_req.linear_in = st_d.ctrl.module_on && st_d.ctrl.linear_in_dma_en &&
                                 linear_sample_in_empty;
        st_d.shaped = shaped_w;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------------
    assign bus_rdata = st_q.rdata;
    assign converter_access_en = st_q.ctrl.module_on;
    // enable for the core's clock gate cell; no clock is gated here
    assign codec_clk_en = st_q.ctrl.codec_clock_gate;
    assign coded_format_sel = st_q.ctrl.coded_format_sel;
    assign companding_format_sel = st_q.ctrl.companding_format_sel;
    assign shaped_sample = st_q.shaped;
    assign irq = st_q.irq;
    assign dma_req = st_q.dma_req;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    ctrl_reset_clear_a : assert property (
        @(posedge sys_clk) rst |=> (st_q.ctrl == '0) && !irq && (dma_req == '0))
        else $error("control or outputs not clear after reset");

    ctrl_write_takes_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (bus_wr && ctrl_hit) |=> (st_q.ctrl == $past(bus_wdata[CTRL_W-1:0])))
        else $error("control write not stored");

    status_off_zero_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (!st_q.ctrl.module_on && bus_rd && stat_hit) |=> (bus_rdata == 16'h0000))
        else $error("status not zero while module off");

    pcm_irq_gate_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && st_q.ctrl.pcm_irq_en && st_q.flags.pcm_service) |-> irq)
        else $error("pcm interrupt missing");

    no_enable_quiet_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        !(st_q.ctrl.pcm_irq_en || st_q.ctrl.fifo_level_irq_en ||
          st_q.ctrl.fifo_error_irq_en) |-> !irq)
        else $error("interrupt raised with all enables clear");

    level_irq_fire_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && st_q.ctrl.fifo_level_irq_en &&
         (st_q.flags.in_fifo_low || st_q.flags.out_fifo_high)) |-> irq)
        else $error("fifo level interrupt missing");

    coded_dma_gate_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && st_q.ctrl.coded_in_dma_en && in_low_now &&
         !st_q.seen.in_low_seen && !(bus_wr && ctrl_hit)) |=> dma_req.coded_in)
        else $error("coded input dma request missing");

    underrun_set_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && core_in_fifo_pop && in_fifo_level == '0 &&
         !(bus_wr && ctrl_hit)) |=> st_q.flags.in_fifo_underrun)
        else $error("underrun flag not set");

    overrun_set_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && core_out_fifo_push && out_fifo_level == FULL_LEVEL &&
         !(bus_wr && ctrl_hit)) |=> st_q.flags.out_fifo_overrun)
        else $error("overrun flag not set");

    freeze_holds_flag_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (frozen && stat_read && st_q.flags.pcm_service && st_q.ctrl.module_on &&
         !(bus_wr && ctrl_hit)) |=> st_q.flags.pcm_service)
        else $error("service flag cleared during freeze");

    read_returns_old_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (stat_read && st_q.ctrl.module_on) |=>
        (bus_rdata[`CVPC_S_IN_LOW] == $past(st_q.flags.in_fifo_low)) &&
        (st_q.flags.in_fifo_low == $past(ev.in_fifo_low)))
        else $error("status read value or clear wrong");

    empty_count_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (stat_read && st_q.ctrl.module_on && in_fifo_level == '0 && out_fifo_level == '0)
        |=> (bus_rdata[`CVPC_S_IN_FREE_HI:`CVPC_S_IN_FREE_LO] == 3'h7) &&
            (bus_rdata[`CVPC_S_OUT_FILL_HI:`CVPC_S_OUT_FILL_LO] == 3'h0))
        else $error("fifo count fields wrong when empty");

    access_follows_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (bus_wr && ctrl_hit) |=> (converter_access_en == $past(bus_wdata[0])))
        else $error("access enable does not follow module-on");

    clock_gate_follows_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (bus_wr && ctrl_hit) |=> (codec_clk_en == $past(bus_wdata[1])))
        else $error("codec clock enable does not follow gate bit");

    off_all_quiet_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (!st_q.ctrl.module_on && !(bus_wr && ctrl_hit)) |=>
        (st_q.flags == '0) && !irq && (dma_req == '0))
        else $error("flags or requests active while module off");

    nearly_full_set_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && out_high_now && !st_q.seen.out_high_seen)
        |=> st_q.flags.out_fifo_high)
        else $error("nearly-full flag not set");

    linear_dma_gate_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && st_q.ctrl.linear_in_dma_en && linear_sample_in_empty &&
         !(bus_wr && ctrl_hit)) |=> dma_req.linear_in)
        else $error("linear input dma request missing");

    format_follows_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (bus_wr && ctrl_hit) |=> (coded_format_sel == $past(bus_wdata[10:9])) &&
        (companding_format_sel == $past(bus_wdata[11])))
        else $error("format selects do not follow control");

    error_irq_fire_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (st_q.ctrl.module_on && st_q.ctrl.fifo_error_irq_en &&
         (st_q.flags.in_fifo_underrun || st_q.flags.out_fifo_overrun)) |-> irq)
        else $error("fifo error interrupt missing");

    out_count_sat_a : assert property (
        @(posedge sys_clk) disable iff (rst)
        (stat_read && st_q.ctrl.module_on && out_fifo_level >= SAT_LEVEL)
        |=> (bus_rdata[`CVPC_S_OUT_FILL_HI:`CVPC_S_OUT_FILL_LO] == 3'h7))
        else $error("output fill count not saturated");

endmodule

`default_nettype wire

//--- hdl/cvpc_pkg.sv
// types shared by the converter control block and its sample shaper
`default_nettype none

package cvpc_pkg;

    // ------------------------------------------------------------------------
    // coded-side pcm format
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CVPC_FMT_MULAW  = 2'h0,
        CVPC_FMT_ALAW   = 2'h1,
        CVPC_FMT_LINEAR = 2'h2,
        CVPC_FMT_RSVD   = 2'h3
    } cvpc_fmt_t;

    // ------------------------------------------------------------------------
    // control register image, most significant field first, module_on last at bit 0
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] atten;
        logic       companding_format_sel;
        cvpc_fmt_t  coded_format_sel;
        logic       linear_in_dma_en;
        logic       linear_out_dma_en;
        logic       coded_in_dma_en;
        logic       coded_out_dma_en;
        logic       fifo_error_irq_en;
        logic       fifo_level_irq_en;
        logic       pcm_irq_en;
        logic       codec_clock_gate;
        logic       module_on;
    } cvpc_ctrl_t;

    typedef struct packed {
        logic out_fifo_overrun;
        logic in_fifo_underrun;
        logic pcm_service;
        logic out_fifo_high;
        logic in_fifo_low;
    } cvpc_flags_t;

    typedef struct packed {
        logic in_low_seen;
        logic out_high_seen;
        logic pcm_need_seen;
    } cvpc_seen_t;

    typedef struct packed {
        logic linear_in;
        logic linear_out;
        logic coded_in;
        logic coded_out;
    } cvpc_dma_t;

    // ------------------------------------------------------------------------
    // whole state of the control block
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  freeze_sync;
        cvpc_seen_t  seen;
        cvpc_ctrl_t  ctrl;
        cvpc_flags_t flags;
        logic [15:0] rdata;
        logic        irq;
        cvpc_dma_t   dma_req;
        logic [15:0] shaped;
    } cvpc_state_t;

endpackage

`default_nettype wire

//--- hdl/cvpc_shaper.sv
// log expansion and attenuation of the sample fed to linear-to-coded conversion
`default_nettype none

module cvpc_shaper (
    input  wire logic [7:0]         log_sample,
    input  wire logic [15:0]        linear_sample_in,
    input  wire cvpc_pkg::cvpc_fmt_t fmt,
    input  wire logic [1:0]         atten,
    output logic [15:0]             shaped
);

    logic [7:0]  a_val;
    logic [7:0]  u_val;
    logic [15:0] a_mag;
    logic [15:0] u_mag;
    logic [15:0] a_lin;
    logic [15:0] u_lin;
    logic [15:0] src;

    // ------------------------------------------------------------------------
    // expansion: a-law lands on 13 bits, mu-law on 14, left-justified
    // ------------------------------------------------------------------------
    always_comb begin
        a_val = log_sample ^ 8'h55;
        a_mag = {8'h00, a_val[3:0], 4'h8};
        if (a_val[6:4] != 3'h0) begin
            a_mag = (a_mag + 16'h0100) << (a_val[6:4] - 3'h1);
        end
        a_lin = a_val[7] ? a_mag : 16'h0000 - a_mag;
        u_val = ~log_sample;
        u_mag = ({8'h00, 1'h0, u_val[3:0], 3'h0} + 16'h0084) << u_val[6:4];
        u_lin = u_val[7] ? 16'h0084 - u_mag : u_mag - 16'h0084;
        unique case (fmt)
            cvpc_pkg::CVPC_FMT_MULAW:  src = u_lin;
            cvpc_pkg::CVPC_FMT_ALAW:   src = a_lin;
            cvpc_pkg::CVPC_FMT_LINEAR: src = linear_sample_in;
            cvpc_pkg::CVPC_FMT_RSVD:   src = 16'h0000;
        endcase
        // sign-extending shift so attenuation keeps polarity
        shaped = 16'($signed(src) >>> atten);
    end

endmodule

`default_nettype wire

//--- sim/cvsd_pcm_ctrl_status_tb_top.sv
// register-level testbench of the converter control and status block
`include "cvpc_consts.svh"
`default_nettype none

module cvsd_pcm_ctrl_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                sys_clk = 1'b0;
    logic                rst = 1'b1;
    logic [23:0]         bus_addr = 24'h00_0000;
    logic                bus_wr = 1'b0;
    logic                bus_rd = 1'b0;
    logic [15:0]         bus_wdata = 16'h0000;
    logic [15:0]         bus_rdata;
    logic                freeze_pin = 1'b0;
    logic [3:0]          in_fifo_level = 4'h8;
    logic [3:0]          out_fifo_level = 4'h0;
    logic                core_in_fifo_pop = 1'b0;
    logic                core_out_fifo_push = 1'b0;
    logic                linear_sample_out_full = 1'b0;
    logic                linear_sample_in_empty = 1'b0;
    logic [7:0]          log_sample = 8'h00;
    logic [15:0]         linear_sample_in = 16'h8000;
    logic                converter_access_en;
    logic                codec_clk_en;
    cvpc_pkg::cvpc_fmt_t coded_format_sel;
    logic                companding_format_sel;
    logic [15:0]         shaped_sample;
    logic                irq;
    cvpc_pkg::cvpc_dma_t dma_req;
    int                  num_errors = 0;
    int                  checks_done = 0;

    cvpc_ctrl_status uut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .freeze_pin(freeze_pin),
        .in_fifo_level(in_fifo_level), .out_fifo_level(out_fifo_level),
        .core_in_fifo_pop(core_in_fifo_pop), .core_out_fifo_push(core_out_fifo_push),
        .linear_sample_out_full(linear_sample_out_full),
        .linear_sample_in_empty(linear_sample_in_empty), .log_sample(log_sample),
        .linear_sample_in(linear_sample_in), .converter_access_en(converter_access_en),
        .codec_clk_en(codec_clk_en), .coded_format_sel(coded_format_sel),
        .companding_format_sel(companding_format_sel), .shaped_sample(shaped_sample),
        .irq(irq), .dma_req(dma_req));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
    endtask

    // read data is registered: look at it just after the edge that follows the strobe
    task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string name);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge sys_clk);
        bus_rd   <= 1'b0;
        #1;
        chk(name, exp, bus_rdata);
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // watchdog: the sequence needs well under a thousand cycles
    // ------------------------------------------------------------------------
    initial begin
        tick(5000);
        num_errors++;
        results();
    end

    initial begin
        tick(12);
        rst <= 1'b0;
        rd(`CVPC_CTRL_ADDR, 16'h0000, "control reset");
        rd(`CVPC_STAT_ADDR, 16'h0000, "status reset");
        wr(`CVPC_CTRL_ADDR, 16'hFDFF);
        rd(`CVPC_CTRL_ADDR, 16'h3DFF, "control readback");
        chk("clock gate", 16'h0001, {15'h0000, codec_clk_en});
        chk("access", 16'h0001, {15'h0000, converter_access_en});
        chk("format", 16'h0006, {13'h0000, companding_format_sel, coded_format_sel});
        // on, gate, level and error irq, coded-in and linear-in dma, linear format
        wr(`CVPC_CTRL_ADDR, 16'h055B);
        rd(`CVPC_STAT_ADDR, 16'h0000, "status idle");
        in_fifo_level <= 4'h3;
        tick(2);
        #1;
        chk("level irq", 16'h0001, {15'h0000, irq});
        chk("coded dma", 16'h0002, {12'h000, dma_req});
        // free count runs seven minus level so both ends match the field's codes
        rd(`CVPC_STAT_ADDR, 16'h0081, "nearly empty");
        chk("irq after read", 16'h0000, {15'h0000, irq});
        rd(`CVPC_STAT_ADDR, 16'h0080, "cleared");
        out_fifo_level <= 4'h5;
        tick(2);
        rd(`CVPC_STAT_ADDR, 16'h0582, "nearly full");
        in_fifo_level <= 4'h0;
        out_fifo_level <= 4'h8;
        tick(1);
        core_in_fifo_pop <= 1'b1;
        core_out_fifo_push <= 1'b1;
        tick(1);
        core_in_fifo_pop <= 1'b0;
        core_out_fifo_push <= 1'b0;
        tick(1);
        #1;
        chk("error irq", 16'h0001, {15'h0000, irq});
        rd(`CVPC_STAT_ADDR, 16'h07F8, "under and overrun");
        freeze_pin <= 1'b1;
        tick(4);
        core_in_fifo_pop <= 1'b1;
        tick(1);
        core_in_fifo_pop <= 1'b0;
        rd(`CVPC_STAT_ADDR, 16'h07E8, "frozen read one");
        rd(`CVPC_STAT_ADDR, 16'h07E8, "frozen read two");
        freeze_pin <= 1'b0;
        tick(4);
        rd(`CVPC_STAT_ADDR, 16'h07E8, "thawed read");
        rd(`CVPC_STAT_ADDR, 16'h07E0, "thawed clear");
        linear_sample_in_empty <= 1'b1;
        tick(3);
        #1;
        chk("linear dma", 16'h0008, {12'h000, dma_req});
        chk("pcm irq off", 16'h0000, {15'h0000, irq});
        rd(`CVPC_STAT_ADDR, 16'h07E4, "pcm service");
        rd(24'hFF_FC34, 16'h0000, "unmapped");
        for (int a = 0; a < 4; a++) begin
            wr(`CVPC_CTRL_ADDR, 16'h0401 | 16'(a << 12));
            tick(3);
            #1;
            chk("shaped", 16'(16'hF000 << (3 - a)), shaped_sample);
        end
        wr(`CVPC_CTRL_ADDR, 16'h0001);
        log_sample <= 8'h80;
        tick(3);
        #1;
        chk("mu-law expand", 16'h7D7C, shaped_sample);
        wr(`CVPC_CTRL_ADDR, 16'h0201);
        log_sample <= 8'hAA;
        tick(3);
        #1;
        chk("a-law expand", 16'h7E00, shaped_sample);
        chk("format a-law", 16'h0001, {13'h0000, companding_format_sel, coded_format_sel});
        wr(`CVPC_CTRL_ADDR, 16'h0000);
        tick(1);
        rd(`CVPC_STAT_ADDR, 16'h0000, "status when off");
        chk("outputs off", 16'h0000, {11'h000, converter_access_en, dma_req});
        results();
    end
endmodule

`default_nettype wire
